// File: hw/ioch_pkg.sv
package ioch_pkg;

	localparam int CHAN_COUNT = 4;
	localparam int CHAN_MAX   = 8;

	// register byte offsets
	localparam logic [7:0] OFF_MODCTRL = 8'h00;
	localparam logic [7:0] OFF_CHSTAT  = 8'h04;
	localparam logic [7:0] OFF_IRQSTAT = 8'h08;
	localparam logic [7:0] OFF_IRQMASK = 8'h0c;
	localparam logic [7:0] OFF_CHCFG   = 8'h10;
	localparam int         CHCFG_STEP  = 4;

	// module control fields
	localparam int MOD_ACTIVE_BIT = 0;
	localparam int MOD_WDOFF_BIT  = 1;

	// channel status fields
	localparam int CHSTAT_OUT_LSB = 0;
	localparam int CHSTAT_INV_LSB = 8;
	localparam int CHSTAT_LF_LSB  = 16;
	localparam int CHSTAT_EN_LSB  = 24;

	// channel configuration fields
	localparam int CFG_TYPE_LSB   = 0;
	localparam int CFG_SIM_BIT    = 2;
	localparam int CFG_ERR_LSB    = 3;
	localparam int CFG_NEG_BIT    = 5;
	localparam int CFG_LFE_BIT    = 6;
	localparam int CFG_SUBST_BIT  = 7;
	localparam int CFG_SIMVAL_BIT = 8;
	localparam int CFG_SIMINV_BIT = 9;
	localparam int CFG_ACTIVE_BIT = 10;

	// interrupt status and mask layout
	localparam int IRQ_W      = 9;
	localparam int IRQ_LF_LSB = 0;
	localparam int IRQ_WD_BIT = 8;

	typedef enum logic [1:0] {
		type_dig_in  = 2'h0,
		type_dig_out = 2'h1,
		type_ana_in  = 2'h2,
		type_ana_out = 2'h3
	} ioch_type_t;

	localparam logic [7:0] CHAN_TYPES_DEFAULT = {type_ana_out, type_ana_in, type_dig_out, type_dig_in};

	typedef enum logic [1:0] {
		ERR_CURRENT = 2'h0,
		ERR_SUBST   = 2'h1,
		ERR_LAST    = 2'h2
	} ioch_err_t;

	localparam logic [1:0] ERR_RESERVED = 2'h3;

	typedef enum logic [1:0] {
		WD_OK    = 2'b00,
		WD_ARMED = 2'b01,
		WD_OFF   = 2'b11
	} ioch_wd_t;

	typedef struct packed {
		logic      sim;
		ioch_err_t errMode;
		logic      negate;
		logic      lfEn;
		logic      subst;
		logic      simVal;
		logic      simInv;
	} ioch_cfg_t;

	localparam ioch_cfg_t CFG_RESET = '{sim: 1'b0, errMode: ERR_CURRENT, negate: 1'b0,
		lfEn: 1'b1, subst: 1'b0, simVal: 1'b0, simInv: 1'b0};
	localparam logic MODACT_RESET = 1'b0;

	// watchdog timing
	localparam int FAIL_LIMIT   = 3;
	localparam int WD_TIME_MS   = 500;
	localparam int CLK_FREQ_KHZ = 200000;
	localparam int WD_CYCLES    = WD_TIME_MS * CLK_FREQ_KHZ;

endpackage : ioch_pkg

// File: hw/ioch_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ioch_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	if (WIDTH < 1) begin : g_bad
		$error("ioch_sync: WIDTH must be at least 1");
	end

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} ioch_sync_t;

	ioch_sync_t state_reg;
	ioch_sync_t state_next;

	always_comb begin
		state_next.meta = din;
		state_next.stable = state_reg.meta;
		if (reset) begin
			state_next = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	assign dout = state_reg.stable;

endmodule : ioch_sync
`default_nettype wire

// File: hw/ioch_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module ioch_watchdog #(
	parameter int WD_CYCLES = ioch_pkg::WD_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic commFail,
	input  wire logic commOk,
	output logic      expired
);

	localparam int TW = $clog2(WD_CYCLES + 1);

	if (WD_CYCLES < 1) begin : g_bad
		$error("ioch_watchdog: WD_CYCLES must be at least 1");
	end

	typedef struct packed {
		ioch_pkg::ioch_wd_t st;
		logic [1:0]         failCnt;
		logic [TW-1:0]      timer;
	} ioch_wdst_t;

	ioch_wdst_t state_reg;
	ioch_wdst_t state_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg.st)
			ioch_pkg::WD_OK: begin
				if (commFail) begin
					if (state_reg.failCnt == 2'(ioch_pkg::FAIL_LIMIT - 1)) begin
						state_next.st = ioch_pkg::WD_ARMED;
						state_next.timer = '0;
					end else begin
						state_next.failCnt = state_reg.failCnt + 2'h1;
					end
				end
			end
			ioch_pkg::WD_ARMED: begin
				if (state_reg.timer == TW'(WD_CYCLES - 1)) begin
					state_next.st = ioch_pkg::WD_OFF;
				end else begin
					state_next.timer = state_reg.timer + TW'(1);
				end
			end
			ioch_pkg::WD_OFF: begin
				state_next.st = ioch_pkg::WD_OFF;
			end
			default: begin
				state_next.st = ioch_pkg::WD_OK;
			end
		endcase
		// any good exchange breaks the run of failures
		if (commOk) begin
			state_next.st = ioch_pkg::WD_OK;
			state_next.failCnt = 2'h0;
			state_next.timer = '0;
		end
		if (reset) begin
			state_next = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	assign expired = (state_reg.st == ioch_pkg::WD_OFF);

	sequence s_thirdFail;
		state_reg.st == ioch_pkg::WD_OK && state_reg.failCnt == 2'(ioch_pkg::FAIL_LIMIT - 1)
			&& commFail && !commOk;
	endsequence

	property p_armAfterThree;
		@(posedge ref_clk) disable iff (reset)
		s_thirdFail |=> state_reg.st == ioch_pkg::WD_ARMED && state_reg.timer == '0;
	endproperty
	a_armAfterThree: assert property (p_armAfterThree) else $error("watchdog not armed");

	property p_offAfterTime;
		@(posedge ref_clk) disable iff (reset)
		$rose(expired) |-> $past(state_reg.st) == ioch_pkg::WD_ARMED
			&& $past(state_reg.timer) == TW'(WD_CYCLES - 1);
	endproperty
	a_offAfterTime: assert property (p_offAfterTime) else $error("watchdog off early");

endmodule : ioch_watchdog
`default_nettype wire

// File: hw/ioch_signal_handler.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ioch_signal_handler #(
	parameter int                  NUM_CH     = ioch_pkg::CHAN_COUNT,
	parameter logic [2*NUM_CH-1:0] CHAN_TYPES = (2*NUM_CH)'(ioch_pkg::CHAN_TYPES_DEFAULT),
	parameter int                  WD_CYCLES  = ioch_pkg::WD_CYCLES
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [NUM_CH-1:0] busValue,
	input  wire logic [NUM_CH-1:0] busInvalid,
	input  wire logic              commFail,
	input  wire logic              commOk,
	input  wire logic [NUM_CH-1:0] leadBreak,
	input  wire logic [NUM_CH-1:0] shortCircuit,
	output logic      [NUM_CH-1:0] chanOut,
	output logic      [NUM_CH-1:0] chanInvalid,
	output logic      [NUM_CH-1:0] chanLineFault,
	output logic      [NUM_CH-1:0] chanEnable,
	output logic                   irq
);

	if (NUM_CH < 1 || NUM_CH > ioch_pkg::CHAN_MAX) begin : g_bad
		$error("ioch_signal_handler: NUM_CH must be 1 to 8");
	end

	typedef struct packed {
		logic                                modActive;
		ioch_pkg::ioch_cfg_t [NUM_CH-1:0]    cfg;
		logic [NUM_CH-1:0]                   lastValid;
		logic [NUM_CH-1:0]                   chOut;
		logic [NUM_CH-1:0]                   chInval;
		logic [NUM_CH-1:0]                   chLf;
		logic [NUM_CH-1:0]                   chEn;
		logic                                wdSeen;
		logic [ioch_pkg::IRQ_W-1:0]          irqStat;
		logic [ioch_pkg::IRQ_W-1:0]          irqMask;
		logic [31:0]                         rdata;
		logic                                slvErr;
	} ioch_state_t;

	ioch_state_t                state_reg;
	ioch_state_t                state_next;
	logic                       wdOff;
	logic [2*NUM_CH-1:0]        faultSync;
	logic [NUM_CH-1:0]          rawSrc;
	logic [NUM_CH-1:0]          invIn;
	logic [NUM_CH-1:0]          errNow;
	logic [NUM_CH-1:0]          chVal;
	logic [NUM_CH-1:0]          lfNow;
	logic                       enNow;
	logic                       hit;
	logic                       wrAcc;
	logic [31:0]                rd;
	logic [ioch_pkg::IRQ_W-1:0] irqSet;
	logic [ioch_pkg::IRQ_W-1:0] irqClr;

	ioch_watchdog #(
		.WD_CYCLES (WD_CYCLES)
	) u_watchdog (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.commFail (commFail),
		.commOk   (commOk),
		.expired  (wdOff)
	);

	// field fault lines from the pins pass a two-stage synchronizer first
	ioch_sync #(
		.WIDTH (2 * NUM_CH)
	) u_faultSync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.din     ({shortCircuit, leadBreak}),
		.dout    (faultSync)
	);

	always_comb begin
		state_next = state_reg;
		hit = 1'b0;
		rd = '0;
		irqSet = '0;
		irqClr = '0;
		rawSrc = '0;
		invIn = '0;
		errNow = '0;
		chVal = '0;
		lfNow = '0;
		wrAcc = psel && penable && pwrite && !state_reg.slvErr;
		enNow = state_reg.modActive && !wdOff;

		if (paddr == ioch_pkg::OFF_MODCTRL) begin
			hit = 1'b1;
			rd[ioch_pkg::MOD_ACTIVE_BIT] = state_reg.modActive;
			rd[ioch_pkg::MOD_WDOFF_BIT] = wdOff;
			if (wrAcc) begin
				state_next.modActive = pwdata[ioch_pkg::MOD_ACTIVE_BIT];
			end
		end
		if (paddr == ioch_pkg::OFF_CHSTAT) begin
			hit = 1'b1;
			rd[ioch_pkg::CHSTAT_OUT_LSB +: NUM_CH] = state_reg.chOut;
			rd[ioch_pkg::CHSTAT_INV_LSB +: NUM_CH] = state_reg.chInval;
			rd[ioch_pkg::CHSTAT_LF_LSB +: NUM_CH] = state_reg.chLf;
			rd[ioch_pkg::CHSTAT_EN_LSB +: NUM_CH] = state_reg.chEn;
		end
		if (paddr == ioch_pkg::OFF_IRQSTAT) begin
			hit = 1'b1;
			rd[ioch_pkg::IRQ_W-1:0] = state_reg.irqStat;
			if (wrAcc) begin
				irqClr = pwdata[ioch_pkg::IRQ_W-1:0];
			end
		end
		if (paddr == ioch_pkg::OFF_IRQMASK) begin
			hit = 1'b1;
			rd[ioch_pkg::IRQ_W-1:0] = state_reg.irqMask;
			if (wrAcc) begin
				state_next.irqMask = pwdata[ioch_pkg::IRQ_W-1:0];
			end
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (paddr == ioch_pkg::OFF_CHCFG + 8'(ioch_pkg::CHCFG_STEP * i)) begin
				hit = 1'b1;
				rd[ioch_pkg::CFG_TYPE_LSB +: 2] = CHAN_TYPES[2*i +: 2];
				rd[ioch_pkg::CFG_SIM_BIT] = state_reg.cfg[i].sim;
				rd[ioch_pkg::CFG_ERR_LSB +: 2] = state_reg.cfg[i].errMode;
				rd[ioch_pkg::CFG_NEG_BIT] = state_reg.cfg[i].negate;
				rd[ioch_pkg::CFG_LFE_BIT] = state_reg.cfg[i].lfEn;
				rd[ioch_pkg::CFG_SUBST_BIT] = state_reg.cfg[i].subst;
				rd[ioch_pkg::CFG_SIMVAL_BIT] = state_reg.cfg[i].simVal;
				rd[ioch_pkg::CFG_SIMINV_BIT] = state_reg.cfg[i].simInv;
				rd[ioch_pkg::CFG_ACTIVE_BIT] = state_reg.chEn[i];
				if (wrAcc) begin
					state_next.cfg[i].sim = pwdata[ioch_pkg::CFG_SIM_BIT];
					// a reserved code leaves the previous strategy in place
					if (pwdata[ioch_pkg::CFG_ERR_LSB +: 2] != ioch_pkg::ERR_RESERVED) begin
						state_next.cfg[i].errMode =
							ioch_pkg::ioch_err_t'(pwdata[ioch_pkg::CFG_ERR_LSB +: 2]);
					end
					state_next.cfg[i].negate = pwdata[ioch_pkg::CFG_NEG_BIT];
					state_next.cfg[i].lfEn = pwdata[ioch_pkg::CFG_LFE_BIT];
					state_next.cfg[i].subst = pwdata[ioch_pkg::CFG_SUBST_BIT];
					state_next.cfg[i].simVal = pwdata[ioch_pkg::CFG_SIMVAL_BIT];
					state_next.cfg[i].simInv = pwdata[ioch_pkg::CFG_SIMINV_BIT];
				end
			end
		end
		// read data is captured in the setup cycle so the access phase needs no wait
		if (psel && !penable) begin
			state_next.rdata = rd;
			state_next.slvErr = !hit;
		end

		for (int i = 0; i < NUM_CH; i++) begin
			rawSrc[i] = state_reg.cfg[i].sim ? state_reg.cfg[i].simVal : busValue[i];
			invIn[i] = state_reg.cfg[i].sim ? state_reg.cfg[i].simInv : busInvalid[i];
			chVal[i] = rawSrc[i] ^ state_reg.cfg[i].negate;
			// line faults are deliberately kept out of the error term
			errNow[i] = wdOff || invIn[i];
			lfNow[i] = state_reg.cfg[i].lfEn && (faultSync[i] || faultSync[NUM_CH+i]);
			if (!errNow[i]) begin
				state_next.lastValid[i] = chVal[i];
				state_next.chOut[i] = chVal[i];
			end else begin
				unique case (state_reg.cfg[i].errMode)
					ioch_pkg::ERR_CURRENT: state_next.chOut[i] = chVal[i];
					ioch_pkg::ERR_SUBST:   state_next.chOut[i] = state_reg.cfg[i].subst;
					ioch_pkg::ERR_LAST:    state_next.chOut[i] = state_reg.lastValid[i];
					default:               state_next.chOut[i] = state_reg.cfg[i].subst;
				endcase
			end
			state_next.chInval[i] = errNow[i];
			if (!enNow) begin
				state_next.chOut[i] = 1'b0;
			end
			state_next.chEn[i] = enNow;
			state_next.chLf[i] = lfNow[i];
			irqSet[ioch_pkg::IRQ_LF_LSB + i] = lfNow[i] && !state_reg.chLf[i];
		end
		irqSet[ioch_pkg::IRQ_WD_BIT] = wdOff && !state_reg.wdSeen;
		state_next.wdSeen = wdOff;
		// a new event beats a clear written in the same cycle
		state_next.irqStat = (state_reg.irqStat & ~irqClr) | irqSet;

		if (reset) begin
			state_next = '0;
			state_next.modActive = ioch_pkg::MODACT_RESET;
			for (int i = 0; i < NUM_CH; i++) begin
				state_next.cfg[i] = ioch_pkg::CFG_RESET;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	assign prdata = state_reg.rdata;
	assign pready = psel && penable;
	assign pslverr = psel && penable && state_reg.slvErr;
	assign chanOut = state_reg.chOut;
	assign chanInvalid = state_reg.chInval;
	assign chanLineFault = state_reg.chLf;
	assign chanEnable = state_reg.chEn;
	assign irq = |(state_reg.irqStat & state_reg.irqMask);

	// a one written to a status bit clears it unless a new event lands in that cycle
	property p_irqClear;
		@(posedge ref_clk) disable iff (reset)
		wrAcc && paddr == ioch_pkg::OFF_IRQSTAT && irqSet == '0
			|=> (state_reg.irqStat & $past(irqClr)) == '0;
	endproperty
	a_irqClear: assert property (p_irqClear) else $error("status bit not cleared");

	property p_wdEvent;
		@(posedge ref_clk) disable iff (reset)
		$rose(wdOff) |=> state_reg.irqStat[ioch_pkg::IRQ_WD_BIT];
	endproperty
	a_wdEvent: assert property (p_wdEvent) else $error("watchdog event not flagged");

	for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
		sequence s_cfgRead;
			psel && !penable && !pwrite
				&& paddr == ioch_pkg::OFF_CHCFG + 8'(ioch_pkg::CHCFG_STEP * i);
		endsequence

		sequence s_inError;
			enNow && errNow[i];
		endsequence

		property p_typeRo;
			@(posedge ref_clk) disable iff (reset)
			s_cfgRead |=> prdata[ioch_pkg::CFG_TYPE_LSB +: 2] == CHAN_TYPES[2*i +: 2];
		endproperty
		a_typeRo: assert property (p_typeRo) else $error("channel type mismatch");

		property p_active;
			@(posedge ref_clk) disable iff (reset)
			1'b1 |=> state_reg.chEn[i] == ($past(state_reg.modActive) && !$past(wdOff));
		endproperty
		a_active: assert property (p_active) else $error("channel active wrong");

		property p_normal;
			@(posedge ref_clk) disable iff (reset)
			enNow && !state_reg.cfg[i].sim && !errNow[i]
				|=> chanOut[i] == ($past(busValue[i]) ^ $past(state_reg.cfg[i].negate));
		endproperty
		a_normal: assert property (p_normal) else $error("bus value not passed");

		property p_sim;
			@(posedge ref_clk) disable iff (reset)
			enNow && state_reg.cfg[i].sim && !errNow[i]
				|=> chanOut[i] == ($past(state_reg.cfg[i].simVal) ^ $past(state_reg.cfg[i].negate));
		endproperty
		a_sim: assert property (p_sim) else $error("simulation value not passed");

		property p_trigger;
			@(posedge ref_clk) disable iff (reset)
			enNow && invIn[i] |=> chanInvalid[i];
		endproperty
		a_trigger: assert property (p_trigger) else $error("error strategy not invoked");

		property p_lfNoSubst;
			@(posedge ref_clk) disable iff (reset)
			enNow && !errNow[i] && lfNow[i] |=> !chanInvalid[i] && chanLineFault[i];
		endproperty
		a_lfNoSubst: assert property (p_lfNoSubst) else $error("line fault caused error");

		property p_current;
			@(posedge ref_clk) disable iff (reset)
			s_inError ##0 state_reg.cfg[i].errMode == ioch_pkg::ERR_CURRENT
				|=> chanOut[i] == ($past(rawSrc[i]) ^ $past(state_reg.cfg[i].negate));
		endproperty
		a_current: assert property (p_current) else $error("current value not kept");

		property p_subst;
			@(posedge ref_clk) disable iff (reset)
			s_inError ##0 state_reg.cfg[i].errMode == ioch_pkg::ERR_SUBST
				|=> chanOut[i] == $past(state_reg.cfg[i].subst);
		endproperty
		a_subst: assert property (p_subst) else $error("substitute value not output");

		property p_last;
			@(posedge ref_clk) disable iff (reset)
			s_inError ##0 state_reg.cfg[i].errMode == ioch_pkg::ERR_LAST
				|=> chanOut[i] == $past(state_reg.lastValid[i]);
		endproperty
		a_last: assert property (p_last) else $error("last valid value not held");

		property p_neg;
			@(posedge ref_clk) disable iff (reset)
			enNow && state_reg.cfg[i].negate && !errNow[i] |=> chanOut[i] != $past(rawSrc[i]);
		endproperty
		a_neg: assert property (p_neg) else $error("negation not applied");

		property p_lineFault;
			@(posedge ref_clk) disable iff (reset)
			lfNow[i] && !state_reg.chLf[i]
				|=> chanLineFault[i] && state_reg.irqStat[ioch_pkg::IRQ_LF_LSB + i];
		endproperty
		a_lineFault: assert property (p_lineFault) else $error("line fault not reported");

		property p_offOut;
			@(posedge ref_clk) disable iff (reset)
			$rose(wdOff) |=> !chanOut[i] && !chanEnable[i] ##1 !chanOut[i];
		endproperty
		a_offOut: assert property (p_offOut) else $error("output not switched off");

		property p_substTag;
			@(posedge ref_clk) disable iff (reset)
			s_inError ##0 state_reg.cfg[i].errMode == ioch_pkg::ERR_SUBST |=> chanInvalid[i];
		endproperty
		a_substTag: assert property (p_substTag) else $error("substitute not tagged invalid");

		property p_errLegal;
			@(posedge ref_clk) disable iff (reset)
			wrAcc && paddr == ioch_pkg::OFF_CHCFG + 8'(ioch_pkg::CHCFG_STEP * i)
				|=> state_reg.cfg[i].errMode != ioch_pkg::ERR_RESERVED;
		endproperty
		a_errLegal: assert property (p_errLegal) else $error("reserved error mode stored");
	end

endmodule : ioch_signal_handler
`default_nettype wire

// File: verification/ioch_com_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the com unit: relays host values and pulses one flag per exchange
module ioch_com_model (
	input  wire logic       ref_clk,
	output logic      [3:0] busValue,
	output logic      [3:0] busInvalid,
	output logic            commFail,
	output logic            commOk
);
	initial begin
		busValue   = 4'h0;
		busInvalid = 4'h0;
		commFail   = 1'b0;
		commOk     = 1'b0;
	end

	task automatic put(input logic [3:0] v, input logic [3:0] inv);
		@(posedge ref_clk);
		busValue   <= v;
		busInvalid <= inv;
	endtask : put

	// an idle cycle follows every pulse, so no two exchanges merge
	task automatic xfer(input logic ok);
		@(posedge ref_clk);
		commOk   <= ok;
		commFail <= !ok;
		@(posedge ref_clk);
		commOk   <= 1'b0;
		commFail <= 1'b0;
	endtask : xfer
endmodule : ioch_com_model
`default_nettype wire

// File: verification/test_ioch_signal_handler.sv
`timescale 1ns/1ps
`default_nettype none
module test_ioch_signal_handler;
	// short watchdog span keeps the run brief
	localparam int WD = 20;
	logic        ref_clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  busValue;
	logic [3:0]  busInvalid;
	logic        commFail;
	logic        commOk;
	logic [3:0]  leadBreak;
	logic [3:0]  shortCircuit;
	logic [3:0]  chanOut;
	logic [3:0]  chanInvalid;
	logic [3:0]  chanLineFault;
	logic [3:0]  chanEnable;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	int          errTotal;
	int          checkCount;

	ioch_com_model com (.ref_clk(ref_clk), .busValue(busValue), .busInvalid(busInvalid),
		.commFail(commFail), .commOk(commOk));

	ioch_signal_handler #(.WD_CYCLES(WD)) DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busValue(busValue), .busInvalid(busInvalid),
		.commFail(commFail), .commOk(commOk), .leadBreak(leadBreak),
		.shortCircuit(shortCircuit), .chanOut(chanOut), .chanInvalid(chanInvalid),
		.chanLineFault(chanLineFault), .chanEnable(chanEnable), .irq(irq));

	function automatic logic [7:0] ca(input int i);
		return ioch_pkg::OFF_CHCFG + 8'(ioch_pkg::CHCFG_STEP * i);
	endfunction : ca

	task automatic reportAndStop();
		$display("checks=%0d errors=%0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : reportAndStop

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checkCount++;
		if (g !== e) begin
			errTotal++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		rd      = prdata;
		er      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask : rchk

	// outputs are registered one edge after their cause; sample clear of the edge
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		errTotal++;
		reportAndStop();
	end

	initial begin
		reset        = 1'b1;
		psel         = 1'b0;
		penable      = 1'b0;
		pwrite       = 1'b0;
		paddr        = 8'h00;
		pwdata       = 32'h0;
		leadBreak    = 4'h0;
		shortCircuit = 4'h0;
		errTotal     = 0;
		checkCount   = 0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		rchk(ioch_pkg::OFF_MODCTRL, 32'h0);
		rchk(ioch_pkg::OFF_CHSTAT, 32'h0);
		rchk(ioch_pkg::OFF_IRQSTAT, 32'h0);
		rchk(ioch_pkg::OFF_IRQMASK, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rchk(ca(i), 32'(ioch_pkg::CHAN_TYPES_DEFAULT[2*i +: 2]) | 32'h40);
		end
		apb(1'b1, ca(0), 32'h443);
		rchk(ca(0), 32'h40);
		apb(1'b1, ioch_pkg::OFF_MODCTRL, 32'h3);
		rchk(ioch_pkg::OFF_MODCTRL, 32'h1);
		rchk(ca(0), 32'h440);
		settle(2);
		cmp(32'(chanEnable), 32'hf);
		apb(1'b0, 8'h80, 32'h0);
		cmp(32'({er, rd[30:0]}), 32'h80000000);
		// misaligned write must be refused and leave the module active
		apb(1'b1, 8'h01, 32'h0);
		cmp(32'(er), 32'h1);
		// negation on channel 1 only
		apb(1'b1, ca(1), 32'h60);
		com.put(4'h5, 4'h0);
		settle(2);
		cmp(32'(chanOut), 32'h7);
		rchk(ioch_pkg::OFF_CHSTAT, 32'h0f000007);
		apb(1'b1, ioch_pkg::OFF_CHSTAT, 32'hffffffff);
		rchk(ioch_pkg::OFF_CHSTAT, 32'h0f000007);
		apb(1'b1, ca(1), 32'h40);
		apb(1'b1, ca(0), 32'h144);
		com.put(4'h0, 4'h0);
		settle(2);
		cmp(32'({chanInvalid[0], chanOut[0]}), 32'h1);
		apb(1'b1, ca(0), 32'h344);
		settle(2);
		cmp(32'({chanInvalid[0], chanOut[0]}), 32'h3);
		// last valid is 1, then invalid values 0 and 1 separate the three modes
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, ca(0), 32'h40 | 32'(m << 3));
			com.put(4'h1, 4'h0);
			settle(2);
			com.put(4'h0, 4'h1);
			settle(2);
			cmp(32'({chanInvalid[0], chanOut[0]}), 32'(2 | (m == 2)));
			com.put(4'h1, 4'h1);
			settle(2);
			cmp(32'({chanInvalid[0], chanOut[0]}), 32'(2 | (m != 1)));
		end
		apb(1'b1, ca(0), 32'h58);
		rchk(ca(0), 32'h450);
		apb(1'b1, ca(0), 32'h40);
		// all channels in current mode: invalid values still pass unchanged
		com.put(4'ha, 4'he);
		settle(2);
		cmp(32'({chanInvalid, chanOut}), 32'hea);
		com.put(4'h0, 4'h0);
		// channel 3 has detection off, so its short must not show
		apb(1'b1, ioch_pkg::OFF_IRQMASK, 32'h4);
		apb(1'b1, ca(3), 32'h0);
		leadBreak    <= 4'hc;
		shortCircuit <= 4'h8;
		settle(6);
		cmp(32'(chanLineFault), 32'h4);
		cmp(32'({chanInvalid, chanOut}), 32'h0);
		cmp(32'(irq), 32'h1);
		rchk(ioch_pkg::OFF_IRQSTAT, 32'h4);
		apb(1'b1, ioch_pkg::OFF_IRQMASK, 32'h0);
		settle(1);
		cmp(32'(irq), 32'h0);
		// channel 2 moves from breakage to short without a new event
		@(posedge ref_clk);
		leadBreak    <= 4'h3;
		shortCircuit <= 4'h7;
		settle(6);
		cmp(32'(chanLineFault), 32'h7);
		cmp(32'({chanInvalid, chanOut}), 32'h0);
		apb(1'b1, ioch_pkg::OFF_IRQSTAT, 32'h5);
		rchk(ioch_pkg::OFF_IRQSTAT, 32'h2);
		leadBreak    <= 4'h0;
		shortCircuit <= 4'h0;
		apb(1'b1, ioch_pkg::OFF_IRQSTAT, 32'h2);
		rchk(ioch_pkg::OFF_IRQSTAT, 32'h0);
		apb(1'b1, ioch_pkg::OFF_IRQMASK, 32'h100);
		// a good exchange between failures restarts the count
		com.xfer(1'b0);
		com.xfer(1'b0);
		com.xfer(1'b1);
		com.xfer(1'b0);
		com.xfer(1'b0);
		settle(WD + 10);
		cmp(32'(chanEnable), 32'hf);
		com.xfer(1'b0);
		settle(WD / 2);
		cmp(32'(chanEnable), 32'hf);
		settle(WD);
		cmp(32'({chanEnable, chanInvalid, chanOut}), 32'h0f0);
		rchk(ioch_pkg::OFF_MODCTRL, 32'h3);
		rchk(ioch_pkg::OFF_IRQSTAT, 32'h100);
		cmp(32'(irq), 32'h1);
		com.xfer(1'b1);
		settle(3);
		cmp(32'(chanEnable), 32'hf);
		reportAndStop();
	end
endmodule : test_ioch_signal_handler
`default_nettype wire
